// [fsgo_top.sv]
// Purpose: Field, line and pixel scheduled toggling of two general outputs
// Assumes: Sync inputs are synchronous levels; one pixel per clock
// Notes: Toggle positions are snapshot when an output is activated
//
// Behaviour
// - Field-repeat mode starts in next field
// - At most two toggles per output per field
// - Field-repeat mode ignores toggle field positions
// - Field-repeat toggles recur until protocol zero
// - Protocol zero one whole field before reactivation
// - Scheduled mode follows primary field counter
// - Burst mode repeats every counter wrap
// - Output level held across field boundaries
// - Scheduled toggles fire once each, never on wraps
// - Delayed shot waits programmed fields first
// - Positions taken when mode is activated
// - Each pin shows table result or own signal
// - Pair control selects function and receiving pins
// - Four-bit table indexed by second,first
// - Counter trigger clears at each field start
// - Counter action codes idle/single/repeat/delay/force
// - Counter maximum and delay are four bits
// - Position is field4, line13, pixel13
// - Disabled output pin stays high impedance
`timescale 1ns/100ps
module fsgo_top
  import fsgo_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Timing references
  input wire logic vertical_sync_i,
  input wire logic line_sync_i,
  // Primary field counter control
  input wire logic counter_trigger_i,
  input wire logic [2:0] counter_action_i,
  input wire logic [3:0] counter_max_i,
  input wire logic [3:0] counter_delay_i,
  // Output configuration, index 0 is output one
  input wire logic [1:0] output_protocol_select_one_i,
  input wire logic [1:0] output_protocol_select_two_i,
  input wire logic [1:0] output_pin_enable_i,
  input wire logic [3:0] pair_truth_table_i,
  input wire logic [1:0] pair_result_route_i,
  // Toggle positions, toggle two in the upper half
  input wire logic [7:0] toggle_field_position_one_i,
  input wire logic [25:0] toggle_line_position_one_i,
  input wire logic [25:0] toggle_pixel_position_one_i,
  input wire logic [7:0] toggle_field_position_two_i,
  input wire logic [25:0] toggle_line_position_two_i,
  input wire logic [25:0] toggle_pixel_position_two_i,
  // Pins, enables active low
  output logic general_output_one_o,
  output logic general_output_two_o,
  output logic [1:0] output_pin_enable_n_o,
  // Status
  output logic [3:0] field_count_o,
  output logic counter_busy_o
);
  fsgo_fc_state_t st_q;
  logic vs_q, ls_q, fs, ls;
  logic [12:0] line_q, pix_q;
  logic [3:0] cnt_q, dcnt_q;
  logic [2:0] pact_q;
  logic pend_q;
  logic counting, at_max;
  logic [1:0] proto [2];
  logic [3:0] fld_in [2][2];
  logic [12:0] lin_in [2][2];
  logic [12:0] pix_in [2][2];
  logic [3:0] fld_q [2][2];
  logic [12:0] lin_q [2][2];
  logic [12:0] pxp_q [2][2];
  logic [1:0] mode_q [2];
  logic [1:0] act_q, ready_q, zero_q, lvl_q;
  logic [1:0] done_q [2];
  logic [1:0] hit [2];
  logic lut_one, lut_two;

  always_comb begin
    proto[0] = output_protocol_select_one_i;
    proto[1] = output_protocol_select_two_i;
    for (int t = 0; t < 2; t++) begin
      fld_in[0][t] = toggle_field_position_one_i[t*4 +: 4];
      fld_in[1][t] = toggle_field_position_two_i[t*4 +: 4];
      lin_in[0][t] = toggle_line_position_one_i[t*13 +: 13];
      lin_in[1][t] = toggle_line_position_two_i[t*13 +: 13];
      pix_in[0][t] = toggle_pixel_position_one_i[t*13 +: 13];
      pix_in[1][t] = toggle_pixel_position_two_i[t*13 +: 13];
    end
  end

  assign fs = vertical_sync_i & ~vs_q;
  assign ls = line_sync_i & ~ls_q;
  assign counting = (st_q == FSGO_FC_SINGLE) || (st_q == FSGO_FC_REPEAT);
  assign at_max = (cnt_q >= counter_max_i);

  // Frame position counters
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      vs_q <= 1'b0;
      ls_q <= 1'b0;
      line_q <= FSGO_POS_RST;
      pix_q <= FSGO_POS_RST;
    end else begin
      vs_q <= vertical_sync_i;
      ls_q <= line_sync_i;
      if (fs) begin
        line_q <= FSGO_POS_RST;
        pix_q <= FSGO_POS_RST;
      end else if (ls) begin
        line_q <= line_q + 13'h0001;
        pix_q <= FSGO_POS_RST;
      end else begin
        pix_q <= pix_q + 13'h0001;
      end
    end
  end

  // Trigger is only honoured at the next field start, then self-clears
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
      pact_q <= FSGO_ACT_IDLE;
    end else if (counter_trigger_i) begin
      pend_q <= 1'b1;
      pact_q <= counter_action_i;
    end else if (fs) begin
      pend_q <= 1'b0;
    end
  end

  // Primary field counter
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_q <= FSGO_FC_IDLE;
      cnt_q <= FSGO_CNT_RST;
      dcnt_q <= FSGO_CNT_RST;
    end else if (fs && pend_q) begin
      if (pact_q == FSGO_ACT_SINGLE) begin
        st_q <= FSGO_FC_SINGLE;
        cnt_q <= FSGO_ONE;
      end else if (pact_q == FSGO_ACT_REPEAT) begin
        st_q <= FSGO_FC_REPEAT;
        cnt_q <= FSGO_ONE;
      end else if (pact_q == FSGO_ACT_DELAY) begin
        st_q <= (counter_delay_i == FSGO_CNT_RST) ? FSGO_FC_SINGLE : FSGO_FC_DELAY;
        cnt_q <= (counter_delay_i == FSGO_CNT_RST) ? FSGO_ONE : FSGO_CNT_RST;
        dcnt_q <= counter_delay_i;
      end else if (pact_q == FSGO_ACT_FORCE) begin
        st_q <= FSGO_FC_IDLE;
        cnt_q <= FSGO_CNT_RST;
      end
    end else if (fs) begin
      unique case (st_q)
        FSGO_FC_IDLE: cnt_q <= FSGO_CNT_RST;
        FSGO_FC_SINGLE: begin
          st_q <= at_max ? FSGO_FC_IDLE : FSGO_FC_SINGLE;
          cnt_q <= at_max ? FSGO_CNT_RST : cnt_q + FSGO_ONE;
        end
        FSGO_FC_REPEAT: cnt_q <= at_max ? FSGO_ONE : cnt_q + FSGO_ONE;
        FSGO_FC_DELAY: begin
          if (dcnt_q == FSGO_ONE) begin
            st_q <= FSGO_FC_SINGLE;
            cnt_q <= FSGO_ONE;
          end
          dcnt_q <= dcnt_q - FSGO_ONE;
        end
      endcase
    end
  end

  // Toggle hits; field-repeat ignores the field position
  always_comb begin
    for (int o = 0; o < 2; o++) begin
      for (int t = 0; t < 2; t++) begin
        // Gated by the live select so a hit in the cycle of an idle write is dropped
        hit[o][t] = act_q[o] && proto[o] != FSGO_P_IDLE && line_q == lin_q[o][t] &&
          pix_q == pxp_q[o][t] &&
          ((mode_q[o] == FSGO_P_FIELD) ||
           (counting && cnt_q == fld_q[o][t] &&
            !(mode_q[o] == FSGO_P_SCHED && done_q[o][t])));
      end
    end
  end

  // Activation, quiet-field tracking and output levels
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      act_q <= 2'h0;
      ready_q <= 2'h3;
      zero_q <= 2'h3;
      lvl_q <= 2'h0;
      for (int o = 0; o < 2; o++) begin
        mode_q[o] <= FSGO_P_IDLE;
        done_q[o] <= 2'h0;
        for (int t = 0; t < 2; t++) begin
          fld_q[o][t] <= FSGO_CNT_RST;
          lin_q[o][t] <= FSGO_POS_RST;
          pxp_q[o][t] <= FSGO_POS_RST;
        end
      end
    end else begin
      for (int o = 0; o < 2; o++) begin
        if (proto[o] == FSGO_P_IDLE) begin
          act_q[o] <= 1'b0;
          mode_q[o] <= FSGO_P_IDLE;
          done_q[o] <= 2'h0;
          if (fs) begin
            ready_q[o] <= zero_q[o];
            zero_q[o] <= 1'b1;
          end
        end else begin
          zero_q[o] <= 1'b0;
          // A rewrite without a quiet field is ignored
          if (fs && !act_q[o] && ready_q[o]) begin
            act_q[o] <= 1'b1;
            ready_q[o] <= 1'b0;
            mode_q[o] <= proto[o];
            for (int t = 0; t < 2; t++) begin
              fld_q[o][t] <= fld_in[o][t];
              lin_q[o][t] <= lin_in[o][t];
              pxp_q[o][t] <= pix_in[o][t];
            end
          end
          for (int t = 0; t < 2; t++) begin
            if (hit[o][t] && mode_q[o] == FSGO_P_SCHED) begin
              done_q[o][t] <= 1'b1;
            end
          end
        end
        // Level only moves on a hit, so it spans field edges
        lvl_q[o] <= lvl_q[o] ^ hit[o][0] ^ hit[o][1];
      end
    end
  end

  fsgo_pair_lut u_lut (
    .first_i(lvl_q[0]),
    .second_i(lvl_q[1]),
    .table_i(pair_truth_table_i),
    .route_i(pair_result_route_i),
    .first_o(lut_one),
    .second_o(lut_two)
  );

  // Registered pins and status
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      general_output_one_o <= 1'b0;
      general_output_two_o <= 1'b0;
      output_pin_enable_n_o <= 2'h3;
      field_count_o <= FSGO_CNT_RST;
      counter_busy_o <= 1'b0;
    end else begin
      general_output_one_o <= lut_one;
      general_output_two_o <= lut_two;
      output_pin_enable_n_o <= ~output_pin_enable_i;
      field_count_o <= cnt_q;
      counter_busy_o <= (st_q != FSGO_FC_IDLE);
    end
  end

  property p_start_at_field;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(act_q[0]) |-> $past(fs) && $past(ready_q[0]);
  endproperty
  a_start_at_field: assert property (p_start_at_field) else $error("activation off field edge");

  property p_field_mode_hit;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      act_q[0] && proto[0] != FSGO_P_IDLE && mode_q[0] == FSGO_P_FIELD && line_q == lin_q[0][0] &&
      pix_q == pxp_q[0][0] && !hit[0][1] |=> lvl_q[0] != $past(lvl_q[0]);
  endproperty
  a_field_mode_hit: assert property (p_field_mode_hit) else $error("field toggle missed");

  property p_sched_once;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      mode_q[0] == FSGO_P_SCHED && done_q[0][0] |-> !hit[0][0];
  endproperty
  a_sched_once: assert property (p_sched_once) else $error("scheduled toggle repeated");

  property p_trig_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      fs && !counter_trigger_i |=> !pend_q;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

  property p_force_idle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      fs && pend_q && pact_q == FSGO_ACT_FORCE |=> st_q == FSGO_FC_IDLE ##1
        !counter_busy_o && field_count_o == FSGO_CNT_RST;
  endproperty
  a_force_idle: assert property (p_force_idle) else $error("force idle ignored");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      fs && !pend_q && st_q == FSGO_FC_REPEAT && at_max |=> st_q == FSGO_FC_REPEAT && cnt_q == FSGO_ONE;
  endproperty
  a_wrap: assert property (p_wrap) else $error("repeat counter failed to wrap");

  property p_delay_end;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      fs && !pend_q && st_q == FSGO_FC_DELAY && dcnt_q == FSGO_ONE |=>
        st_q == FSGO_FC_SINGLE && cnt_q == FSGO_ONE;
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("delayed shot start wrong");

  property p_pin_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !output_pin_enable_i[0] |=> output_pin_enable_n_o[0];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin driven");

  property p_idle_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      proto[0] == FSGO_P_IDLE ##1 proto[0] == FSGO_P_IDLE |-> $stable(lvl_q[0]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle output moved");

  property p_pin_lut;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      pair_result_route_i[0] |=> general_output_one_o ==
        $past(pair_truth_table_i[{lvl_q[1], lvl_q[0]}]);
  endproperty
  a_pin_lut: assert property (p_pin_lut) else $error("pin not table result");
endmodule

// [fsgo_pkg.sv]
// Purpose: Shared constants and the pair look-up module for the scheduled outputs
// Assumes: One pixel clock, signals synchronous to it
// Notes: The look-up module is purely combinational; the top registers its result
`timescale 1ns/100ps
package fsgo_pkg;
  localparam int unsigned FSGO_FLD_W = 4;
  localparam int unsigned FSGO_POS_W = 13;
  localparam int unsigned FSGO_ACT_W = 3;
  localparam int unsigned FSGO_PROTO_W = 2;
  localparam int unsigned FSGO_LUT_W = 4;
  // Legacy location of the pair table control word, field [13:10]
  localparam logic [7:0] FSGO_LUT_ADDR = 8'h52;
  localparam int unsigned FSGO_LUT_LSB = 10;
  localparam logic [7:0] FSGO_TRIG_ADDR = 8'h50;
  // Counter actions
  localparam logic [2:0] FSGO_ACT_IDLE = 3'h0;
  localparam logic [2:0] FSGO_ACT_SINGLE = 3'h1;
  localparam logic [2:0] FSGO_ACT_REPEAT = 3'h2;
  localparam logic [2:0] FSGO_ACT_DELAY = 3'h3;
  localparam logic [2:0] FSGO_ACT_FORCE = 3'h7;
  // Output protocols
  localparam logic [1:0] FSGO_P_IDLE = 2'h0;
  localparam logic [1:0] FSGO_P_FIELD = 2'h1;
  localparam logic [1:0] FSGO_P_SCHED = 2'h2;
  localparam logic [1:0] FSGO_P_BURST = 2'h3;
  // Reset values and the count step
  localparam logic [3:0] FSGO_CNT_RST = 4'h0;
  localparam logic [12:0] FSGO_POS_RST = 13'h0000;
  localparam logic [3:0] FSGO_ONE = 4'h1;
  typedef enum logic [1:0] {
    FSGO_FC_IDLE = 2'b00,
    FSGO_FC_SINGLE = 2'b01,
    FSGO_FC_REPEAT = 2'b10,
    FSGO_FC_DELAY = 2'b11
  } fsgo_fc_state_t;
endpackage

module fsgo_pair_lut
  import fsgo_pkg::*;
(
  // Raw toggle levels
  input wire logic first_i,
  input wire logic second_i,
  // Table and routing
  input wire logic [3:0] table_i,
  input wire logic [1:0] route_i,
  // Pin levels
  output logic first_o,
  output logic second_o
);
  logic res;
  always_comb begin
    res = table_i[{second_i, first_i}];
    first_o = route_i[0] ? res : first_i;
    second_o = route_i[1] ? res : second_i;
  end
endmodule

// [fsgo_load.sv]
// Purpose: Shutter load model on the two general output pins
// Assumes: Both pins carry a pull-down on the board
// Notes: A released pin reads the pull level, never the last driven value
`timescale 1ns/100ps
module fsgo_load (
  // Pin drive from the device
  input wire logic [1:0] level_i,
  input wire logic [1:0] oe_n_i,
  // Levels seen by the load
  output logic [1:0] seen_o
);
  tri0 [1:0] pin_w;
  assign pin_w[0] = oe_n_i[0] ? 1'bz : level_i[0];
  assign pin_w[1] = oe_n_i[1] ? 1'bz : level_i[1];
  assign seen_o = pin_w;
endmodule

// [field_scheduled_gp_outputs_test.sv]
// Purpose: Self-checking bench for the field scheduled general outputs
// Assumes: Fields of 100 clocks, line start at clock 50 of each field
// Notes: Checks sample well clear of toggle edges, so latency slips stay tolerant
`timescale 1ns/100ps
module field_scheduled_gp_outputs_test
  import fsgo_pkg::*;
;
  typedef struct {string nm; logic [10:0] ex;} fsgo_note_t;
  fsgo_note_t notes_q[$];
  event sample_ev;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int smp[4] = '{5, 23, 45, 73};
  logic [3:0] ro = 4'b0110;
  logic [3:0] rt = 4'b1100;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic vs = 1'b0;
  logic ls = 1'b0;
  logic trig = 1'b0;
  logic [2:0] act = 3'h0;
  logic [3:0] cmax = 4'h0;
  logic [3:0] cdelay = 4'h0;
  logic [3:0] tbl = 4'h0;
  logic [1:0] p1 = 2'h0;
  logic [1:0] p2 = 2'h0;
  logic [1:0] en = 2'h0;
  logic [1:0] route = 2'h0;
  logic [7:0] fpos1 = 8'h11;
  logic [7:0] fpos2 = 8'h11;
  logic [25:0] line1 = {13'h0001, 13'h0000};
  logic [25:0] line2 = {13'h0001, 13'h0000};
  logic [25:0] pix1 = {13'h000A, 13'h000A};
  logic [25:0] pix2 = {13'h001E, 13'h001E};
  logic g1, g2, busy;
  logic [1:0] oe_n, seen;
  logic [3:0] fc;
  wire [10:0] obs = {fc, busy, oe_n, seen, g2, g1};

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= (cyc == 99) ? 0 : cyc + 1;
    vs <= (cyc == 99);
    ls <= (cyc == 49);
  end

  fsgo_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .vertical_sync_i(vs),
    .line_sync_i(ls), .counter_trigger_i(trig), .counter_action_i(act),
    .counter_max_i(cmax), .counter_delay_i(cdelay), .output_protocol_select_one_i(p1),
    .output_protocol_select_two_i(p2), .output_pin_enable_i(en),
    .pair_truth_table_i(tbl), .pair_result_route_i(route),
    .toggle_field_position_one_i(fpos1), .toggle_line_position_one_i(line1),
    .toggle_pixel_position_one_i(pix1), .toggle_field_position_two_i(fpos2),
    .toggle_line_position_two_i(line2), .toggle_pixel_position_two_i(pix2),
    .general_output_one_o(g1), .general_output_two_o(g2),
    .output_pin_enable_n_o(oe_n), .field_count_o(fc), .counter_busy_o(busy));
  fsgo_load i_load (.level_i({g2, g1}), .oe_n_i(oe_n), .seen_o(seen));

  // Oldest note is compared against the outputs settled before this edge
  always @(sample_ev) begin
    fsgo_note_t n;
    n = notes_q.pop_front();
    n_compared++;
    if (obs !== n.ex) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n.nm, n.ex, obs);
    end
  end

  task automatic test_done;
    // Let the checker take the last note before the verdict
    @(negedge sys_clk_i);
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_cyc(int c);
    int i;
    for (i = 0; i < 250; i++) begin
      @(posedge sys_clk_i);
      if (cyc == c) return;
    end
    bad_count++;
    $display("ERROR wait expected %0d seen timeout", c);
    test_done();
  endtask
  task automatic skip(int n);
    repeat (n) wait_cyc(99);
  endtask
  task automatic note(string nm, logic [10:0] ex);
    notes_q.push_back('{nm: nm, ex: ex});
    -> sample_ev;
  endtask
  // One trigger a field at most, so the pending action is never overwritten
  task automatic fire(logic [2:0] a);
    act <= a;
    trig <= 1'b1;
    @(posedge sys_clk_i);
    trig <= 1'b0;
  endtask
  function automatic logic [10:0] pk(logic [3:0] f, logic b, logic [1:0] oen, logic o2,
    logic o1);
    return {f, b, oen, o2 & ~oen[1], o1 & ~oen[0], o2, o1};
  endfunction

  initial begin
    int k, s, f;
    logic o, t, r1, r2;
    void'($urandom(32'hDF476103));
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    note("reset", pk(4'h0, 1'b0, 2'b11, 1'b0, 1'b0));
    en <= 2'b01;
    wait_cyc(60);
    p1 <= FSGO_P_FIELD;
    p2 <= FSGO_P_FIELD;
    wait_cyc(73);
    note("before_start", pk(4'h0, 1'b0, 2'b10, 1'b0, 1'b0));
    for (k = 0; k < 4; k++) begin
      wait_cyc(0);
      tbl <= 4'($urandom);
      route <= k[1:0];
      if (k == 2) pix1 <= 26'h3FFFFFF;
      for (s = 0; s < 4; s++) begin
        wait_cyc(smp[s]);
        o = ro[s];
        t = rt[s];
        r1 = route[0] ? tbl[{t, o}] : o;
        r2 = route[1] ? tbl[{t, o}] : t;
        note("pair_pins", pk(4'h0, 1'b0, 2'b10, r2, r1));
      end
    end
    wait_cyc(90);
    p1 <= FSGO_P_IDLE;
    p2 <= FSGO_P_IDLE;
    route <= 2'h0;
    pix1 <= {13'h000A, 13'h000A};
    wait_cyc(50);
    p1 <= FSGO_P_FIELD;
    wait_cyc(23);
    note("early_restart", pk(4'h0, 1'b0, 2'b10, 1'b0, 1'b0));
    wait_cyc(50);
    p1 <= FSGO_P_IDLE;
    skip(2);
    wait_cyc(50);
    p1 <= FSGO_P_FIELD;
    wait_cyc(23);
    note("restart", pk(4'h0, 1'b0, 2'b10, 1'b0, 1'b1));
    wait_cyc(30);
    p1 <= FSGO_P_IDLE;
    wait_cyc(90);
    note("idle_hold", pk(4'h0, 1'b0, 2'b10, 1'b0, 1'b1));
    en <= 2'b11;
    wait_cyc(50);
    p2 <= FSGO_P_SCHED;
    fpos2 <= 8'h31;
    pix2 <= {13'h000A, 13'h000A};
    cmax <= 4'h4;
    fire(FSGO_ACT_SINGLE);
    for (f = 1; f < 6; f++) begin
      wait_cyc(45);
      note("sched_mid", pk(4'(f <= 4 ? f : 0), f <= 4, 2'b00, f <= 3, 1'b1));
      wait_cyc(90);
      note("sched_end", pk(4'(f <= 4 ? f : 0), f <= 4, 2'b00, f <= 2, 1'b1));
    end
    p2 <= FSGO_P_IDLE;
    skip(2);
    wait_cyc(50);
    p1 <= FSGO_P_BURST;
    p2 <= FSGO_P_SCHED;
    fpos1 <= 8'h21;
    fpos2 <= 8'h21;
    cmax <= 4'h2;
    fire(FSGO_ACT_REPEAT);
    for (f = 0; f < 4; f++) begin
      wait_cyc(45);
      note("burst_mid", pk(4'(f % 2 + 1), 1'b1, 2'b00, f < 2, 1'b0));
      wait_cyc(90);
      note("burst_end", pk(4'(f % 2 + 1), 1'b1, 2'b00, f == 0, f % 2 == 1));
    end
    fire(FSGO_ACT_FORCE);
    wait_cyc(45);
    note("forced_idle", pk(4'h0, 1'b0, 2'b00, 1'b0, 1'b1));
    p1 <= FSGO_P_IDLE;
    p2 <= FSGO_P_IDLE;
    fire(3'h4);
    wait_cyc(45);
    note("test_code", pk(4'h0, 1'b0, 2'b00, 1'b0, 1'b1));
    skip(1);
    wait_cyc(50);
    p1 <= FSGO_P_SCHED;
    fpos1 <= 8'h11;
    cmax <= 4'h1;
    cdelay <= 4'h2;
    fire(FSGO_ACT_DELAY);
    for (f = 0; f < 4; f++) begin
      wait_cyc(45);
      note("delay_mid", pk(4'(f == 2), f < 3, 2'b00, 1'b0, f != 2));
      wait_cyc(90);
      note("delay_end", pk(4'(f == 2), f < 3, 2'b00, 1'b0, 1'b1));
    end
    test_done();
  end
endmodule
